// ===== hdl/ulpi_regs_pkg.sv
package ulpi_regs_pkg;
  localparam logic [5:0] ADDR_RISE_W    = 6'h0D;
  localparam logic [5:0] ADDR_FALL_W    = 6'h10;
  localparam logic [5:0] ADDR_STAT      = 6'h13;
  localparam logic [5:0] ADDR_LATCH     = 6'h14;
  localparam logic [5:0] ADDR_DEBUG     = 6'h15;
  localparam logic [5:0] ADDR_SCRATCH_W = 6'h16;
  localparam logic [5:0] ADDR_EXT_ESC   = 6'h2F;
  localparam logic [5:0] ADDR_HOLE_LO   = 6'h19;
  localparam logic [5:0] ADDR_HOLE_HI   = 6'h2E;
  localparam logic [5:0] ADDR_POWER_W   = 6'h3D;
  localparam logic [7:0] EXT_LIMIT      = 8'h40;
  localparam logic [7:0] ENABLE_RESET   = 8'h1F;
  localparam logic [7:0] ZERO_RESET     = 8'h00;
  localparam logic [7:0] SRC_MASK       = 8'h1F;
  localparam logic [7:0] LINE_MASK      = 8'h03;
  localparam int         PWR_BV_FALL    = 3;
  localparam int         PWR_BV_RISE    = 2;
  localparam logic [7:0] POWER_MASK     = 8'h0C;
  // command byte codes on the link
  localparam logic [1:0] CMD_SPECIAL    = 2'h0;
  localparam logic [1:0] CMD_WRITE      = 2'h2;
  localparam logic [1:0] CMD_READ       = 2'h3;
  localparam logic [5:0] CMD_EXT_ADDR   = 6'h2F;
  // write mode offsets within a register triple
  localparam logic [1:0] OP_WRITE       = 2'h0;
  localparam logic [1:0] OP_SET         = 2'h1;
  localparam logic [1:0] OP_CLEAR       = 2'h2;
  // rx command field layout
  localparam int         RXC_ALT_INT    = 7;
  localparam int         RXC_SESS_VALID = 3;
  localparam int         RXC_VBUS_VALID = 2;
  localparam int         SYNC_STAGES    = 3;
endpackage

// ===== hdl/ulpi_level_sync.sv
// three-stage synchroniser; output changes once stages two and three agree
module ulpi_level_sync
  import ulpi_regs_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // filtered level: per bit, take a new value only when two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// ===== hdl/ulpi_phy_latch_debug_power_regs.sv
// transceiver register bank behind the link interface (link clock domain)
module ulpi_phy_latch_debug_power_regs
  import ulpi_regs_pkg::*;
(
  // core clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // analog sources, core domain
  input  wire logic [4:0] intr_src,
  input  wire logic [1:0] line_state,
  input  wire logic       bvalid,
  input  wire logic       low_power_enter,
  input  wire logic       serial_mode_enter,
  // link side, on the link clock
  input  wire logic       link_clk,
  input  wire logic       link_rst,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            dir,
  output logic            nxt,
  input  wire logic       stp
);
  typedef enum {
    ST_IDLE, ST_EXT, ST_WDATA, ST_TURN, ST_RDATA, ST_BACK, ST_RXC, ST_RXC_BACK
  } state_t;

  // register index within a read/write/set/clear triple
  function automatic logic [1:0] triple_op(input logic [5:0] a, input logic [5:0] base);
    triple_op = 2'(a - base);
  endfunction

  function automatic logic in_triple(input logic [5:0] a, input logic [5:0] base);
    in_triple = (a >= base) && (a <= base + 6'h02);
  endfunction

  function automatic logic [7:0] apply_op(input logic [7:0] old, input logic [7:0] wd,
                                          input logic [1:0] op);
    case (op)
      OP_SET:   apply_op = old | wd;
      OP_CLEAR: apply_op = old & ~wd;
      default:  apply_op = wd;
    endcase
  endfunction

  // sources cross into the link domain
  // [9] serial entry, [8] low-power entry, [7] b-valid, [6:5] line state, [4:0] sources
  logic [9:0] src_raw;
  logic [9:0] src_sync;
  assign src_raw = {serial_mode_enter, low_power_enter, bvalid, line_state, intr_src};

  ulpi_level_sync #(.W(10)) u_sync (
    .clk (link_clk),
    .rst (link_rst),
    .d   (src_raw),
    .q   (src_sync)
  );

  logic [4:0] src_now;
  logic [4:0] src_prev_q;
  logic       bv_now;
  logic       bv_prev_q;
  logic       lp_prev_q;
  logic       ser_prev_q;
  assign src_now = src_sync[4:0];
  assign bv_now  = src_sync[7];

  state_t     state_q;
  logic [5:0] addr_q;
  logic       ext_q;
  logic [7:0] rise_en_q;
  logic [7:0] fall_en_q;
  logic [7:0] latch_q;
  logic [7:0] scratch_q;
  logic [7:0] power_q;
  logic       alt_pend_q;
  logic       src_pend_q;
  logic       wr_fire;
  logic       latch_rd;
  logic [7:0] rd_val;

  // previous samples for edge detection
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      src_prev_q <= '0;
      bv_prev_q  <= 1'b0;
      lp_prev_q  <= 1'b0;
      ser_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_now;
      bv_prev_q  <= bv_now;
      lp_prev_q  <= src_sync[8];
      ser_prev_q <= src_sync[9];
    end
  end

  logic [4:0] rise_ev;
  logic [4:0] fall_ev;
  logic [4:0] unmasked_ev;
  logic       lp_entry;
  assign rise_ev     = src_now & ~src_prev_q;
  assign fall_ev     = ~src_now & src_prev_q;
  assign unmasked_ev = (rise_ev & rise_en_q[4:0]) | (fall_ev & fall_en_q[4:0]);
  assign lp_entry    = (src_sync[8] & ~lp_prev_q) | (src_sync[9] & ~ser_prev_q);

  // latch: events win over a clear in the same cycle
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      latch_q <= ZERO_RESET;
    end else begin
      latch_q <= (((latch_rd || lp_entry) ? ZERO_RESET : latch_q)
                  | {3'b000, unmasked_ev}) & SRC_MASK;
    end
  end

  // link protocol state machine
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      state_q <= ST_IDLE;
      addr_q  <= '0;
      ext_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (alt_pend_q || src_pend_q) begin
            state_q <= ST_RXC;
          end else if (data_in[7:6] == CMD_WRITE || data_in[7:6] == CMD_READ) begin
            addr_q  <= data_in[5:0];
            ext_q   <= (data_in[7:6] == CMD_READ);
            state_q <= (data_in[5:0] == CMD_EXT_ADDR) ? ST_EXT
                     : (data_in[7:6] == CMD_WRITE) ? ST_WDATA : ST_TURN;
          end
        end
        ST_EXT: begin
          // extended address; only the low 64 alias the immediate set
          addr_q  <= data_in[5:0];
          state_q <= (data_in >= EXT_LIMIT) ? ST_IDLE : (ext_q ? ST_TURN : ST_WDATA);
        end
        ST_WDATA: state_q <= ST_IDLE;
        ST_TURN:  state_q <= ST_RDATA;
        ST_RDATA: state_q <= ST_BACK;
        ST_BACK:  state_q <= ST_IDLE;
        ST_RXC:   state_q <= ST_RXC_BACK;
        ST_RXC_BACK: state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  assign wr_fire  = (state_q == ST_WDATA) && !stp;
  assign latch_rd = (state_q == ST_RDATA) && (addr_q == ADDR_LATCH);

  // writable registers; addresses 19h..2Eh and other holes decode to nothing
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      rise_en_q <= ENABLE_RESET;
      fall_en_q <= ENABLE_RESET;
      scratch_q <= ZERO_RESET;
      power_q   <= ZERO_RESET;
    end else if (wr_fire) begin
      if (in_triple(addr_q, ADDR_RISE_W)) begin
        rise_en_q <= apply_op(rise_en_q, data_in, triple_op(addr_q, ADDR_RISE_W));
      end
      if (in_triple(addr_q, ADDR_FALL_W)) begin
        fall_en_q <= apply_op(fall_en_q, data_in, triple_op(addr_q, ADDR_FALL_W));
      end
      if (in_triple(addr_q, ADDR_SCRATCH_W)) begin
        scratch_q <= apply_op(scratch_q, data_in, triple_op(addr_q, ADDR_SCRATCH_W));
      end
      if (in_triple(addr_q, ADDR_POWER_W)) begin
        power_q <= apply_op(power_q, data_in, triple_op(addr_q, ADDR_POWER_W));
      end
    end
  end

  // read decode
  always_comb begin
    rd_val = ZERO_RESET;
    if (in_triple(addr_q, ADDR_RISE_W)) begin
      rd_val = rise_en_q;
    end else if (in_triple(addr_q, ADDR_FALL_W)) begin
      rd_val = fall_en_q;
    end else if (addr_q == ADDR_STAT) begin
      rd_val = {3'b000, src_now};
    end else if (addr_q == ADDR_LATCH) begin
      rd_val = latch_q;
    end else if (addr_q == ADDR_DEBUG) begin
      rd_val = {6'h00, src_sync[6:5]} & LINE_MASK;
    end else if (in_triple(addr_q, ADDR_SCRATCH_W)) begin
      rd_val = scratch_q;
    end else if (in_triple(addr_q, ADDR_POWER_W)) begin
      rd_val = power_q;
    end
  end

  // rx command requests; raise wins over the send that drains it
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      alt_pend_q <= 1'b0;
      src_pend_q <= 1'b0;
    end else begin
      if ((power_q[PWR_BV_FALL] && bv_prev_q && !bv_now) ||
          (power_q[PWR_BV_RISE] && !bv_prev_q && bv_now)) begin
        alt_pend_q <= 1'b1;
      end else if (state_q == ST_RXC) begin
        alt_pend_q <= 1'b0;
      end
      if (|unmasked_ev) begin
        src_pend_q <= 1'b1;
      end else if (state_q == ST_RXC) begin
        src_pend_q <= 1'b0;
      end
    end
  end

  // data_out from flip-flops; dir, data_oe and nxt are decoded combinationally
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      data_out <= ZERO_RESET;
    end else if (state_q == ST_TURN) begin
      data_out <= rd_val;
    end else if (state_q == ST_IDLE && (alt_pend_q || src_pend_q)) begin
      data_out <= {alt_pend_q, 3'b000, src_now[2], src_now[1], src_sync[6:5]};
    end
  end

  assign dir     = (state_q == ST_TURN) || (state_q == ST_RDATA) || (state_q == ST_BACK)
                 || (state_q == ST_RXC) || (state_q == ST_RXC_BACK);
  assign data_oe = (state_q == ST_RDATA) || (state_q == ST_RXC);
  assign nxt     = (state_q == ST_IDLE && (data_in[7:6] == CMD_WRITE || data_in[7:6] == CMD_READ)
                    && !(alt_pend_q || src_pend_q))
                 || state_q == ST_EXT || state_q == ST_WDATA;

  // a rising b-valid edge is signalled while the rise enable is set
  a_alt_int_send: assert property (@(posedge link_clk) disable iff (link_rst)
    (power_q[PWR_BV_RISE] && !bv_prev_q && bv_now && state_q == ST_IDLE)
      |-> ##[1:6] (state_q == ST_RXC && data_out[RXC_ALT_INT]))
    else $error("alt interrupt rx command missing");

  a_latch_clear: assert property (@(posedge link_clk) disable iff (link_rst)
    (latch_rd && !(|unmasked_ev)) |=> latch_q == ZERO_RESET)
    else $error("latch not cleared after read");

  a_latch_reserved: assert property (@(posedge link_clk) disable iff (link_rst)
    latch_q[7:5] == 3'b000)
    else $error("latch reserved bits set");

  a_latch_set: assert property (@(posedge link_clk) disable iff (link_rst)
    (|unmasked_ev) |=> ((latch_q[4:0] & $past(unmasked_ev)) == $past(unmasked_ev)))
    else $error("latch missed an event");

  a_scratch_hold: assert property (@(posedge link_clk) disable iff (link_rst)
    !wr_fire |=> $stable(scratch_q))
    else $error("scratch changed without write");

  a_power_hold: assert property (@(posedge link_clk) disable iff (link_rst)
    (wr_fire && !in_triple(addr_q, ADDR_POWER_W)) |=> $stable(power_q))
    else $error("power control changed by other address");

  a_debug_read: assert property (@(posedge link_clk) disable iff (link_rst)
    (state_q == ST_TURN && addr_q == ADDR_DEBUG) |=> data_out[7:2] == 6'h00)
    else $error("debug upper bits not zero");

  a_alt_fall: assert property (@(posedge link_clk) disable iff (link_rst)
    (power_q[PWR_BV_FALL] && bv_prev_q && !bv_now) |=> alt_pend_q || state_q == ST_RXC)
    else $error("falling b-valid not queued");

  // a falling b-valid must reach the link, not only the queue
  a_alt_fall_send: assert property (@(posedge link_clk) disable iff (link_rst)
    (power_q[PWR_BV_FALL] && bv_prev_q && !bv_now && state_q == ST_IDLE)
      |-> ##[1:6] (state_q == ST_RXC && data_out[RXC_ALT_INT]))
    else $error("falling alt interrupt rx command missing");

  // mode entry wipes the latch unless a new event lands at once
  a_mode_clear: assert property (@(posedge link_clk) disable iff (link_rst)
    (lp_entry && !(|unmasked_ev)) |=> latch_q == ZERO_RESET)
    else $error("latch not cleared on mode entry");

  // writes into the hole leave scratch, power and both enable registers alone
  a_hole_quiet: assert property (@(posedge link_clk) disable iff (link_rst)
    (wr_fire && addr_q >= ADDR_HOLE_LO && addr_q <= ADDR_HOLE_HI)
      |=> ($stable(scratch_q) && $stable(power_q) && $stable(rise_en_q) && $stable(fall_en_q)))
    else $error("hole write changed a register");

  // extended address byte after the escape is always taken
  a_ext_taken: assert property (@(posedge link_clk) disable iff (link_rst)
    (state_q == ST_EXT) |-> nxt)
    else $error("extended address not accepted");

  // an rx command owns the bus for its data cycle
  a_rxc_drive: assert property (@(posedge link_clk) disable iff (link_rst)
    (state_q == ST_RXC) |-> (dir && data_oe))
    else $error("rx command not driven");

  // debug low bits follow the synchronised line state
  a_debug_value: assert property (@(posedge link_clk) disable iff (link_rst)
    (state_q == ST_TURN && addr_q == ADDR_DEBUG) |=> data_out[1:0] == $past(src_sync[6:5]))
    else $error("debug line state wrong");
endmodule

// ===== tb/ulpi_link_model.sv
// link controller model: issues register commands, tallies alternate interrupt rx commands
module ulpi_link_model
  import ulpi_regs_pkg::*;
(
  // link clock
  input  wire logic       link_clk,
  // ulpi bus
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       dir,
  input  wire logic       nxt,
  output logic            stp,
  // status to bench
  output logic            tmo,
  output logic      [7:0] alt_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rd_busy;

  initial begin
    data_in = 8'h00;
    stp     = 1'b0;
    tmo     = 1'b0;
    alt_cnt = 8'h00;
    rd_busy = 1'b0;
  end

  // rx commands outside reads; alternate interrupt ones are counted
  always @(negedge link_clk) begin
    if (dir === 1'b1 && data_oe === 1'b1 && !rd_busy && data_out[RXC_ALT_INT] === 1'b1) begin
      alt_cnt <= alt_cnt + 8'h01;
    end
  end

  // hold a byte from just after an edge until nxt is seen high
  task automatic send(input logic [7:0] b);
    int k;
    @(posedge link_clk);
    data_in <= b;
    for (k = 0; k < 20; k++) begin
      @(negedge link_clk);
      if (nxt === 1'b1) break;
    end
    if (k == 20) tmo = 1'b1;
  endtask

  // extended accesses stay below 40h, callers never pass more
  task automatic wr(input logic ext, input logic [7:0] a, input logic [7:0] d);
    if (ext) begin
      send({CMD_WRITE, CMD_EXT_ADDR});
      send(a);
    end else begin
      send({CMD_WRITE, a[5:0]});
    end
    send(d);
    @(posedge link_clk);
    data_in <= 8'h00;
  endtask

  // bus is released during the turn: a changing pattern, never a clean idle
  task automatic rd(input logic ext, input logic [7:0] a, output logic [7:0] d);
    int k;
    d = 8'hXX;
    rd_busy = 1'b1;
    if (ext) begin
      send({CMD_READ, CMD_EXT_ADDR});
      send(a);
    end else begin
      send({CMD_READ, a[5:0]});
    end
    for (k = 0; k < 20; k++) begin
      @(negedge link_clk);
      if (data_oe === 1'b1) d = data_out;
      if (dir !== 1'b1) break;
      data_in <= ~data_in;
    end
    data_in <= 8'h00;
    if (k == 20) tmo = 1'b1;
    rd_busy = 1'b0;
  endtask
endmodule

// ===== tb/ulpi_phy_latch_debug_power_regs_test.sv
// bench: register traffic through the link model, sources driven on clk
module ulpi_phy_latch_debug_power_regs_test
  import ulpi_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst, bvalid, low_power_enter, serial_mode_enter;
  logic [4:0] intr_src;
  logic [1:0] line_state;
  logic       link_clk, link_rst, data_oe, dir, nxt, stp, tmo;
  logic [7:0] data_in, data_out, alt_cnt, v, n0;
  int         errors, n_tests, i;

  // core clock, and a link clock with its own phase
  always #2 clk = ~clk;
  initial begin
    clk      = 1'b0;
    link_clk = 1'b0;
    #0.7;
    forever #80 link_clk = ~link_clk;
  end

  ulpi_phy_latch_debug_power_regs ulpi_phy_latch_debug_power_regs_i (
    .clk(clk), .rst(rst), .intr_src(intr_src), .line_state(line_state), .bvalid(bvalid),
    .low_power_enter(low_power_enter), .serial_mode_enter(serial_mode_enter),
    .link_clk(link_clk), .link_rst(link_rst), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .dir(dir), .nxt(nxt), .stp(stp)
  );
  ulpi_link_model ulpi_link_model_i (
    .link_clk(link_clk), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .dir(dir), .nxt(nxt), .stp(stp), .tmo(tmo), .alt_cnt(alt_cnt)
  );

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rd(input logic ext, input logic [7:0] a, input logic [7:0] exp);
    ulpi_link_model_i.rd(ext, a, v);
    chk($sformatf("reg %h ext %b", a, ext), exp, v);
  endtask

  // sources pass a synchroniser and may raise rx commands first
  task automatic settle;
    repeat (12) @(posedge link_clk);
  endtask

  // a stuck handshake ends the run
  always @(posedge tmo) begin
    errors++;
    wrap_up();
  end

  initial begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    link_rst = 1'b1;
    intr_src = 5'h00;
    line_state = 2'h1;
    bvalid = 1'b0;
    low_power_enter = 1'b0;
    serial_mode_enter = 1'b0;
    repeat (5) @(posedge link_clk);
    @(negedge clk);
    rst = 1'b0;
    link_rst = 1'b0;
    settle();
    // reset values; the latch is read although the link may skip it
    chk_rd(0, 8'h14, 8'h00);
    chk_rd(0, 8'h15, 8'h01);
    chk_rd(0, 8'h16, 8'h00);
    chk_rd(0, 8'h3D, 8'h00);
    chk_rd(0, 8'h0D, 8'h1F);
    @(negedge clk) line_state = 2'h2;
    settle();
    chk_rd(0, 8'h15, 8'h02);
    // scratch and power: write, set and clear aliases
    ulpi_link_model_i.wr(0, 8'h16, 8'hA5);
    chk_rd(0, 8'h16, 8'hA5);
    ulpi_link_model_i.wr(0, 8'h17, 8'h0A);
    chk_rd(0, 8'h16, 8'hAF);
    ulpi_link_model_i.wr(0, 8'h18, 8'h0F);
    chk_rd(0, 8'h16, 8'hA0);
    ulpi_link_model_i.wr(0, 8'h3D, 8'h08);
    ulpi_link_model_i.wr(0, 8'h3E, 8'h04);
    chk_rd(0, 8'h3D, 8'h0C);
    ulpi_link_model_i.wr(0, 8'h3F, 8'h08);
    chk_rd(0, 8'h3D, 8'h04);
    // unimplemented holes leave everything alone
    ulpi_link_model_i.wr(0, 8'h20, 8'hFF);
    ulpi_link_model_i.wr(0, 8'h2E, 8'h55);
    chk_rd(0, 8'h20, 8'h00);
    chk_rd(0, 8'h16, 8'hA0);
    chk_rd(0, 8'h35, 8'h00);
    // extended addresses reach the immediate set through the escape
    ulpi_link_model_i.wr(1, 8'h16, 8'h5A);
    chk_rd(0, 8'h16, 8'h5A);
    chk_rd(1, 8'h3D, 8'h04);
    // each source edge latches its own bit; a read clears it
    for (i = 0; i < 5; i++) begin
      @(negedge clk) intr_src[i] = 1'b1;
      settle();
      chk_rd(0, 8'h14, 8'h01 << i);
      chk_rd(0, 8'h14, 8'h00);
    end
    // masked falling edges latch nothing
    ulpi_link_model_i.wr(0, 8'h10, 8'h00);
    @(negedge clk) intr_src = 5'h00;
    settle();
    chk_rd(0, 8'h14, 8'h00);
    // mode entry clears a latched bit
    @(negedge clk) intr_src[0] = 1'b1;
    settle();
    @(negedge clk) low_power_enter = 1'b1;
    settle();
    chk_rd(0, 8'h14, 8'h00);
    @(negedge clk) intr_src[1] = 1'b1;
    settle();
    @(negedge clk) serial_mode_enter = 1'b1;
    settle();
    chk_rd(0, 8'h14, 8'h00);
    // b-valid edges flagged only while enabled (counted as comparisons)
    ulpi_link_model_i.wr(0, 8'h3D, 8'h0C);
    n0 = alt_cnt;
    @(negedge clk) bvalid = 1'b1;
    settle();
    chk("alt rise", n0 + 8'h01, alt_cnt);
    @(negedge clk) bvalid = 1'b0;
    settle();
    chk("alt fall", n0 + 8'h02, alt_cnt);
    ulpi_link_model_i.wr(0, 8'h3D, 8'h00);
    @(negedge clk) bvalid = 1'b1;
    settle();
    chk("alt off", n0 + 8'h02, alt_cnt);
    wrap_up();
  end
endmodule
